/* codec_irq_pkg.sv */
// Constants for the codec interrupt request block
// Notes on behaviour
// - Four events can request an interrupt
// - Per-event enable bit in mask register
// - Per-event status bit readable by host
// - Corruption and end bits mirror pins inverted
// - End-of-image bit mirrors pin inverted, slave decompression
// - Active-video bit set after last active line
// - Two-pass: active-video only in first pass
// - Start clears status bits and event pins
// - Status valid regardless of enable bits
// - Enabled event asserts interrupt request low
// - Pending interrupt plus end enters service wait
// - Request holds until host reads status
// - Status read releases request, returns idle
// - Process counter modulo four on end bit fall (end pin rise)
// - Counter cleared only by reset, to one
package codec_irq_pkg;

	// ------------------------------------------------------------
	// Register addresses (internal ten-bit space)
	// ------------------------------------------------------------
	localparam logic [9:0] ADDR_INTERRUPT_ENABLE_MASK = 10'h03c;
	localparam logic [9:0] ADDR_INTERRUPT_EVENT_STATUS = 10'h03d;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BIT_DATA_CORRUPTION = 3;
	localparam int BIT_END_OF_PROCESS = 2;
	localparam int BIT_END_OF_IMAGE = 1;
	localparam int BIT_END_OF_ACTIVE_VIDEO = 0;
	localparam int BIT_COUNT_LO = 6;
	localparam int BIT_COUNT_HI = 7;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [3:0] MASK_RESET = 4'h0;
	localparam logic [1:0] COUNT_RESET = 2'h1;

	// ------------------------------------------------------------
	// States
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_BUSY = 3'b010,
		ST_SERVICE_WAIT = 3'b100
	} proc_state_e;

endpackage

/* codec_interrupt_request.sv */
// Interrupt request logic of the image codec
`timescale 1ns/1ps
module codec_interrupt_request (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_start,
	input wire logic i_data_corruption_event,
	input wire logic i_end_of_process_event,
	input wire logic i_end_of_image_event,
	input wire logic i_last_active_line_done,
	input wire logic i_two_pass_mode,
	input wire logic i_second_pass,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [9:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	output logic o_data_corruption_flag_n,
	output logic o_end_of_process_flag_n,
	output logic o_end_of_image_flag_n,
	output logic o_end_of_active_video_flag,
	output logic o_codec_irq_n,
	output logic o_service_wait_state,
	output logic o_idle,
	output logic o_start_taken,
	output logic [1:0] o_process_cycle_counter
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [3:0] interrupt_enable_mask;
	logic [3:0] status;
	logic [1:0] process_cycle_counter;
	logic irq;
	logic end_prev;
	codec_irq_pkg::proc_state_e state;
	logic status_read;
	logic start_ok;
	logic end_of_active_video_flag_event;
	logic [3:0] events;

	assign status_read = i_reg_rd && (i_reg_addr == codec_irq_pkg::ADDR_INTERRUPT_EVENT_STATUS);
	assign start_ok = i_start && (state == codec_irq_pkg::ST_IDLE);
	assign end_of_active_video_flag_event = i_last_active_line_done && !(i_two_pass_mode && i_second_pass);
	assign events = {i_data_corruption_event, i_end_of_process_event, i_end_of_image_event, end_of_active_video_flag_event};

	// ------------------------------------------------------------
	// Mask register
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			interrupt_enable_mask <= codec_irq_pkg::MASK_RESET;
		end else if (i_reg_wr && i_reg_addr == codec_irq_pkg::ADDR_INTERRUPT_ENABLE_MASK) begin
			interrupt_enable_mask <= i_reg_wdata[3:0];
		end
	end

	// ------------------------------------------------------------
	// Event status, cleared at start; set wins
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			status <= 4'h0;
		end else begin
			status <= ((start_ok) ? 4'h0 : status) | events;
		end
	end

	// ------------------------------------------------------------
	// Process counter on end-of-process rising edge of pin
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			end_prev <= 1'b0;
			process_cycle_counter <= codec_irq_pkg::COUNT_RESET;
		end else begin
			end_prev <= status[codec_irq_pkg::BIT_END_OF_PROCESS];
			if (end_prev && !status[codec_irq_pkg::BIT_END_OF_PROCESS]) begin
				process_cycle_counter <= process_cycle_counter + 2'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupt request and state
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq <= 1'b0;
		end else if (|(events & interrupt_enable_mask)) begin
			irq <= 1'b1;
		end else if (status_read) begin
			irq <= 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= codec_irq_pkg::ST_IDLE;
		end else begin
			case (state)
				codec_irq_pkg::ST_IDLE: begin
					if (i_start) begin
						state <= codec_irq_pkg::ST_BUSY;
					end
				end
				codec_irq_pkg::ST_BUSY: begin
					if (i_end_of_process_event) begin
						state <= (irq || |(events & interrupt_enable_mask)) ?
							codec_irq_pkg::ST_SERVICE_WAIT : codec_irq_pkg::ST_IDLE;
					end
				end
				codec_irq_pkg::ST_SERVICE_WAIT: begin
					if (status_read) begin
						state <= codec_irq_pkg::ST_IDLE;
					end
				end
				default: begin
					state <= codec_irq_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Read data and outputs
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_reg_rdata <= 8'h00;
		end else if (i_reg_addr == codec_irq_pkg::ADDR_INTERRUPT_ENABLE_MASK) begin
			o_reg_rdata <= {4'h0, interrupt_enable_mask};
		end else if (i_reg_addr == codec_irq_pkg::ADDR_INTERRUPT_EVENT_STATUS) begin
			o_reg_rdata <= {process_cycle_counter, 2'b00, status};
		end else begin
			o_reg_rdata <= 8'h00;
		end
	end

	assign o_data_corruption_flag_n = !status[codec_irq_pkg::BIT_DATA_CORRUPTION];
	assign o_end_of_process_flag_n = !status[codec_irq_pkg::BIT_END_OF_PROCESS];
	assign o_end_of_image_flag_n = !status[codec_irq_pkg::BIT_END_OF_IMAGE];
	assign o_end_of_active_video_flag = status[codec_irq_pkg::BIT_END_OF_ACTIVE_VIDEO];
	assign o_codec_irq_n = !irq;
	assign o_service_wait_state = (state == codec_irq_pkg::ST_SERVICE_WAIT);
	assign o_idle = (state == codec_irq_pkg::ST_IDLE);
	assign o_start_taken = start_ok;
	assign o_process_cycle_counter = process_cycle_counter;

endmodule // codec_interrupt_request

/* codec_irq_monitor.sv */
// Port checker for the interrupt request block
`timescale 1ns/1ps
module codec_irq_monitor (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_reg_rd,
	input wire logic [9:0] i_reg_addr,
	input wire logic i_end_of_process_event,
	input wire logic o_codec_irq_n,
	input wire logic o_service_wait_state,
	input wire logic o_idle,
	input wire logic o_start_taken,
	input wire logic [1:0] o_process_cycle_counter
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	wire ack = i_reg_rd && i_reg_addr == codec_irq_pkg::ADDR_INTERRUPT_EVENT_STATUS;
	a_irq_hold: assert property (!o_codec_irq_n && !ack |=> !o_codec_irq_n) else $error("irq drop");
	a_irq_release: assert property ($rose(o_codec_irq_n) |-> $past(ack) && o_idle) else $error("irq rise");
	a_wait_irq: assert property (o_service_wait_state |-> !o_codec_irq_n) else $error("wait irq");
	a_wait_entry: assert property (!o_codec_irq_n && i_end_of_process_event && !o_idle
		|=> o_service_wait_state) else $error("no wait");
	a_wait_hold: assert property (o_service_wait_state && !ack |=> o_service_wait_state) else $error("left");
	a_wait_exit: assert property (o_service_wait_state && ack |=> o_idle) else $error("no idle");
	a_start_idle: assert property (o_start_taken |-> o_idle) else $error("start");
	a_count_step: assert property ($changed(o_process_cycle_counter) |->
		o_process_cycle_counter == $past(o_process_cycle_counter) + 2'h1) else $error("count");
	cover property (o_service_wait_state);
	cover property ($rose(o_codec_irq_n));
	cover property ($changed(o_process_cycle_counter));
endmodule // codec_irq_monitor
bind codec_interrupt_request codec_irq_monitor u_mon (.*);

/* host_side.sv */
// Host model for internal register access
`timescale 1ns/1ps
module host_side (
	input wire logic i_ref_clk,
	input wire logic [7:0] i_rdata,
	output logic o_wr,
	output logic o_rd,
	output logic [9:0] o_addr,
	output logic [7:0] o_wdata
);
	initial {o_wr, o_rd, o_addr, o_wdata} = '0;
	task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d, output logic [7:0] q);
		{o_wr, o_rd, o_addr, o_wdata} = {w, !w, a, d};
		@(negedge i_ref_clk);
		q = i_rdata;
		{o_wr, o_rd, o_addr, o_wdata} = {2'h0, ~a, ~d};
		@(negedge i_ref_clk);
	endtask
endmodule // host_side

/* codec_interrupt_request_tb.sv */
// Bench for the interrupt request block
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; $display("BAD %0t %h %h", $time, g, e); end end
module codec_interrupt_request_tb;
	logic i_ref_clk, i_rst_n, i_start, i_data_corruption_event, i_end_of_process_event, i_end_of_image_event, i_reg_wr;
	logic i_last_active_line_done, i_two_pass_mode, i_second_pass, i_reg_rd, o_end_of_active_video_flag, o_idle;
	logic o_data_corruption_flag_n, o_end_of_process_flag_n, o_end_of_image_flag_n, o_codec_irq_n, o_start_taken;
	logic o_service_wait_state;
	logic [9:0] i_reg_addr;
	logic [7:0] i_reg_wdata, o_reg_rdata, q;
	logic [1:0] o_process_cycle_counter;
	int err_total, check_count;
	localparam logic [9:0] ST = codec_irq_pkg::ADDR_INTERRUPT_EVENT_STATUS;
	localparam logic [9:0] MK = codec_irq_pkg::ADDR_INTERRUPT_ENABLE_MASK;
	codec_interrupt_request DUT (.*);
	host_side host (.i_ref_clk, .i_rdata(o_reg_rdata), .o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_addr(i_reg_addr),
		.o_wdata(i_reg_wdata));
	initial begin
		i_ref_clk = 1'h0;
		forever #25 i_ref_clk = ~i_ref_clk;
	end
	task automatic pulse(ref logic s);
		s = 1'h1;
		@(negedge i_ref_clk);
		s = 1'h0;
		@(negedge i_ref_clk);
	endtask
	task automatic rdchk(input logic [9:0] a, input logic [7:0] e);
		host.acc(1'h0, a, 8'h00, q);
		`CHK(q, e)
	endtask
	task automatic final_report;
		$display("%0d checks %0d bad", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge i_ref_clk);
		err_total++;
		final_report();
	end
	initial begin
		{i_rst_n, i_start, i_data_corruption_event, i_end_of_process_event, i_end_of_image_event} = '0;
		{i_last_active_line_done, i_two_pass_mode, i_second_pass} = '0;
		repeat (3) @(negedge i_ref_clk);
		i_rst_n = 1'h1;
		rdchk(MK, 8'h00);
		rdchk(10'h3ff, 8'h00);
		host.acc(1'h1, ST, 8'hff, q);
		rdchk(ST, 8'h40);
		$display("test regs done");
		host.acc(1'h1, MK, 8'h08, q);
		pulse(i_end_of_image_event);
		`CHK(o_codec_irq_n, 1'h1)
		`CHK(o_end_of_image_flag_n, 1'h0)
		rdchk(ST, 8'h42);
		pulse(i_start);
		pulse(i_data_corruption_event);
		`CHK(o_codec_irq_n, 1'h0)
		`CHK(o_data_corruption_flag_n, 1'h0)
		pulse(i_end_of_process_event);
		`CHK(o_service_wait_state, 1'h1)
		`CHK(o_end_of_process_flag_n, 1'h0)
		rdchk(ST, 8'h4c);
		`CHK({o_codec_irq_n, o_idle}, 2'h3)
		pulse(i_start);
		rdchk(ST, 8'h80);
		$display("test irq done");
		repeat (2) begin
			pulse(i_end_of_process_event);
			pulse(i_start);
		end
		rdchk(ST, 8'h00);
		$display("test count done");
		i_two_pass_mode = 1'h1;
		i_second_pass = 1'h1;
		pulse(i_last_active_line_done);
		`CHK(o_end_of_active_video_flag, 1'h0)
		i_second_pass = 1'h0;
		pulse(i_last_active_line_done);
		`CHK(o_end_of_active_video_flag, 1'h1)
		$display("test video done");
		final_report();
	end
endmodule // codec_interrupt_request_tb
